/* verilog/test_port_consts.svh */
`ifndef TEST_PORT_CONSTS_SVH
`define TEST_PORT_CONSTS_SVH
// command codes
`define CC_VOLUME_UP       8'h33
`define CC_VOLUME_DOWN     8'h34
`define CC_STATUS_REQ      8'h35
`define CC_INDIC_REQ       8'h36
`define CC_POWER_REQ       8'h37
`define CC_ALERT_REQ       8'h38
`define CC_SHORT_TEXT_REQ  8'h39
`define CC_KEYS            8'h3A
`define CC_ALERT_ON        8'h3C
`define CC_ALERT_OFF       8'h3D
`define CC_HOOK_ON         8'h40
`define CC_HOOK_OFF        8'h41
`define CC_BEARER_SEL      8'h46
`define CC_TX_POWER_SET    8'h50
`define CC_STATUS_REPLY    8'h5B
`define CC_INDIC_REPLY     8'h5C
`define CC_POWER_REPLY     8'h5D
`define CC_SHORT_TEXT      8'h65
`define CC_NO_SHORT_TEXT   8'h66
`define CC_INTERNAL_FAULT  8'hF0
`define CC_UNRECOGNISED    8'hF1
`define CC_UNPERFORMABLE   8'hF2
`define CC_FULL_RESET      8'hFF
// code ranges
`define CC_GENERAL_LO      8'h32
`define CC_GENERAL_HI      8'hB3
`define CC_MAKER_A_LO      8'hB4
`define CC_MAKER_A_HI      8'hD1
`define CC_MAKER_B_LO      8'hD2
`define CC_MAKER_B_HI      8'hEF
`define CC_ERROR_LO        8'hF0
// link flow-control characters
`define LINK_ACK           8'h06
`define LINK_NAK           8'h15
`define LINK_XON           8'h11
`define LINK_XOFF          8'h13
// key codes
`define KEY_HASH           8'h23
`define KEY_STAR           8'h2A
`define KEY_PLUS           8'h2B
`define KEY_DIGIT_LO       8'h30
`define KEY_DIGIT_HI       8'h39
`define KEY_END            8'h12
`define KEY_SEND           8'h14
`endif

/* verilog/test_port_pkg.sv */
package test_port_pkg;
   typedef enum {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV} host_state_t;
   typedef enum {CLS_OK, CLS_RESERVED, CLS_MAKER_A, CLS_MAKER_B} code_class_t;
endpackage : test_port_pkg

/* verilog/frame_mem.sv */
`timescale 1ns/1ps
module frame_mem #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : frame_mem

/* verilog/test_port_host.sv */
//////////////////////////////////////////////////////////////////////////////
// Function
// - every message opens with one command octet
// - undefined general codes are never sent
// - maker codes 180-209 only when enabled
// - codes 210-239 never sent in conformance
// - undefined error-range codes are never sent
// - no code equals a link control character
// - keystroke command carries key codes per octet
// - key codes are the fixed decimal set
// - bearer field opens with its length octet
// - only the simulator sends full reset
// - either side may send unrecognised error
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "test_port_consts.svh"
module test_port_host #(
   parameter int MAX_LEN = 256,
   parameter int AW      = 8
) (
   // clock and reset
   input  wire logic       MCLK,
   input  wire logic       RST,
   // user command port
   input  wire logic       CMD_VALID,
   input  wire logic [7:0] CMD_BYTE,
   input  wire logic       CMD_LAST,
   input  wire logic       MAKER_A_EN,
   output logic            CMD_READY,
   output logic            CMD_REJECT,
   // frame out toward the link layer
   output logic            TX_VALID,
   output logic [7:0]      TX_BYTE,
   output logic            TX_LAST,
   input  wire logic       TX_READY,
   // frame in from the link layer
   input  wire logic       RX_VALID,
   input  wire logic [7:0] RX_BYTE,
   input  wire logic       RX_LAST,
   // decoded answers
   output logic            REPLY_VALID,
   output logic [7:0]      REPLY_CODE,
   output logic [7:0]      REPLY_ARG,
   output logic            ALERT_ACTIVE,
   output logic            FAULT_SEEN,
   output logic            PROTO_ERROR
);
   test_port_pkg::host_state_t state_reg;
   test_port_pkg::code_class_t cls;
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW-1:0] len_reg;
   logic [7:0]    code_reg;
   logic [7:0]    mem_rdata;
   logic          first_reg;
   logic          is_known;
   logic          is_sim_code;
   logic          key_ok;
   logic          msg_bad;
   logic          body_bad_reg;
   logic          wr_en;
   logic [AW-1:0] rd_next;
   logic [AW:0]   rx_cnt_reg;

   //////////////////////////////////////////////////////////////////////////
   // code checks on the first octet, key-code checks on the octets after it
   always_comb
   begin
      is_sim_code = 1'b0;
      case (CMD_BYTE)
         `CC_VOLUME_UP, `CC_VOLUME_DOWN, `CC_STATUS_REQ, `CC_INDIC_REQ, `CC_POWER_REQ,
         `CC_ALERT_REQ, `CC_SHORT_TEXT_REQ, `CC_KEYS, `CC_HOOK_ON, `CC_HOOK_OFF,
         `CC_BEARER_SEL, `CC_TX_POWER_SET, `CC_UNRECOGNISED, `CC_FULL_RESET:
            is_sim_code = 1'b1;
         default: is_sim_code = 1'b0;
      endcase
      if (CMD_BYTE inside {`LINK_ACK, `LINK_NAK, `LINK_XON, `LINK_XOFF})
         cls = test_port_pkg::CLS_RESERVED;
      else if (CMD_BYTE >= `CC_MAKER_A_LO && CMD_BYTE <= `CC_MAKER_A_HI)
         cls = test_port_pkg::CLS_MAKER_A;
      else if (CMD_BYTE >= `CC_MAKER_B_LO && CMD_BYTE <= `CC_MAKER_B_HI)
         cls = test_port_pkg::CLS_MAKER_B;
      else if (is_sim_code)
         cls = test_port_pkg::CLS_OK;
      else
         cls = test_port_pkg::CLS_RESERVED;
   end

   always_comb
   begin
      is_known = (cls == test_port_pkg::CLS_OK) ||
                 (cls == test_port_pkg::CLS_MAKER_A && MAKER_A_EN);
      key_ok = (CMD_BYTE == `KEY_HASH) || (CMD_BYTE == `KEY_STAR) || (CMD_BYTE == `KEY_PLUS) ||
               (CMD_BYTE >= `KEY_DIGIT_LO && CMD_BYTE <= `KEY_DIGIT_HI) ||
               (CMD_BYTE == `KEY_END) || (CMD_BYTE == `KEY_SEND);
      // the octet being taken counts too, so a bad closing key is still caught
      msg_bad = first_reg ? !is_known : (body_bad_reg || (code_reg == `CC_KEYS && !key_ok));
   end

   //////////////////////////////////////////////////////////////////////////
   // command staging; the whole message is held until its closing octet is checked
   assign wr_en = (state_reg == test_port_pkg::ST_IDLE) && CMD_VALID && CMD_READY;

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         wr_ptr_reg   <= '0;
         first_reg    <= 1'b1;
         code_reg     <= 8'h00;
         body_bad_reg <= 1'b0;
         CMD_REJECT   <= 1'b0;
      end
      else
      begin
         CMD_REJECT <= 1'b0;
         if (wr_en)
         begin
            if (first_reg)
            begin
               code_reg     <= CMD_BYTE;
               body_bad_reg <= !is_known;
            end
            else if (code_reg == `CC_KEYS && !key_ok)
               body_bad_reg <= 1'b1;
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
            first_reg  <= CMD_LAST;
            if (CMD_LAST)
            begin
               // a refused message is dropped whole, never half-sent
               CMD_REJECT <= msg_bad;
               wr_ptr_reg <= '0;
            end
         end
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RST)
         len_reg <= '0;
      else if (wr_en && CMD_LAST)
         len_reg <= wr_ptr_reg; // length octet is user data, sent verbatim
   end

   frame_mem #(.DEPTH(MAX_LEN), .AW(AW)) u_mem (
      .clk   (MCLK),
      .we    (wr_en),
      .waddr (wr_ptr_reg),
      .wdata (CMD_BYTE),
      .raddr (rd_next + AW'(1)), // prefetch the octet after the one on TX_BYTE
      .rdata (mem_rdata)
   );

   //////////////////////////////////////////////////////////////////////////
   // transmit and, except after full reset, await one answer frame
   assign rd_next = (state_reg == test_port_pkg::ST_SEND && TX_VALID && TX_READY) ?
                    rd_ptr_reg + AW'(1) : rd_ptr_reg;

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         state_reg  <= test_port_pkg::ST_IDLE;
         rd_ptr_reg <= '0;
         TX_VALID   <= 1'b0;
         TX_BYTE    <= 8'h00;
         TX_LAST    <= 1'b0;
         CMD_READY  <= 1'b0;
      end
      else
      begin
         case (state_reg)
            test_port_pkg::ST_IDLE:
            begin
               CMD_READY <= 1'b1;
               if (wr_en && CMD_LAST && !msg_bad)
               begin
                  CMD_READY  <= 1'b0;
                  rd_ptr_reg <= '0;
                  state_reg  <= test_port_pkg::ST_WAIT;
               end
            end
            test_port_pkg::ST_WAIT:
            begin
               // opening octet comes from code_reg; the memory read register fetches octet 1 meanwhile
               TX_VALID  <= 1'b1;
               TX_BYTE   <= code_reg;
               TX_LAST   <= (len_reg == '0);
               state_reg <= test_port_pkg::ST_SEND;
            end
            test_port_pkg::ST_SEND:
            begin
               if (TX_READY)
               begin
                  if (TX_LAST)
                  begin
                     TX_VALID  <= 1'b0;
                     TX_LAST   <= 1'b0;
                     // full reset expects no answer
                     state_reg <= (code_reg == `CC_FULL_RESET) ?
                                  test_port_pkg::ST_IDLE : test_port_pkg::ST_RECV;
                  end
                  else
                  begin
                     rd_ptr_reg <= rd_next;
                     TX_BYTE    <= mem_rdata;
                     TX_LAST    <= (rd_next == len_reg);
                  end
               end
            end
            test_port_pkg::ST_RECV:
            begin
               if (RX_VALID && RX_LAST)
                  state_reg <= test_port_pkg::ST_IDLE;
            end
            default:
               state_reg <= test_port_pkg::ST_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // answer decode; first octet is the code, second its argument
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         rx_cnt_reg   <= '0;
         REPLY_VALID  <= 1'b0;
         REPLY_CODE   <= 8'h00;
         REPLY_ARG    <= 8'h00;
         ALERT_ACTIVE <= 1'b0;
         FAULT_SEEN   <= 1'b0;
         PROTO_ERROR  <= 1'b0;
      end
      else
      begin
         REPLY_VALID <= 1'b0;
         PROTO_ERROR <= 1'b0;
         if (RX_VALID && state_reg == test_port_pkg::ST_RECV)
         begin
            rx_cnt_reg <= RX_LAST ? '0 : rx_cnt_reg + (AW+1)'(1);
            if (rx_cnt_reg == '0)
            begin
               REPLY_CODE <= RX_BYTE;
               REPLY_ARG  <= 8'h00;
               if (RX_BYTE == `CC_ALERT_ON)
                  ALERT_ACTIVE <= 1'b1;
               if (RX_BYTE == `CC_ALERT_OFF)
                  ALERT_ACTIVE <= 1'b0;
               if (RX_BYTE == `CC_INTERNAL_FAULT)
                  FAULT_SEEN <= 1'b1;
               // expected reply per request
               case (code_reg)
                  `CC_STATUS_REQ:     PROTO_ERROR <= RX_BYTE != `CC_STATUS_REPLY && RX_BYTE < `CC_ERROR_LO;
                  `CC_INDIC_REQ:      PROTO_ERROR <= RX_BYTE != `CC_INDIC_REPLY && RX_BYTE < `CC_ERROR_LO;
                  `CC_POWER_REQ:      PROTO_ERROR <= RX_BYTE != `CC_POWER_REPLY && RX_BYTE < `CC_ERROR_LO;
                  `CC_ALERT_REQ:      PROTO_ERROR <= RX_BYTE != `CC_ALERT_ON && RX_BYTE != `CC_ALERT_OFF &&
                                                     RX_BYTE < `CC_ERROR_LO;
                  `CC_SHORT_TEXT_REQ: PROTO_ERROR <= RX_BYTE != `CC_SHORT_TEXT && RX_BYTE != `CC_NO_SHORT_TEXT &&
                                                     RX_BYTE < `CC_ERROR_LO;
                  default:            PROTO_ERROR <= 1'b0;
               endcase
            end
            else if (rx_cnt_reg == (AW+1)'(1))
            begin
               REPLY_ARG <= RX_BYTE;
            end
            if (RX_LAST)
            begin
               REPLY_VALID <= 1'b1;
            end
         end
         else if (RX_VALID && state_reg == test_port_pkg::ST_IDLE && RX_BYTE == `CC_UNRECOGNISED)
         begin
            // unsolicited error from the station; reported, resend is left to the user
            REPLY_CODE  <= RX_BYTE;
            REPLY_ARG   <= 8'h00;
            REPLY_VALID <= RX_LAST;
         end
      end
   end
endmodule : test_port_host

/* tb/host_properties.sv */
`timescale 1ns/1ps
`include "test_port_consts.svh"
module host_checker (
   // clock and reset
   input wire logic       MCLK,
   input wire logic       RST,
   // command side
   input wire logic       CMD_VALID,
   input wire logic       CMD_LAST,
   input wire logic       CMD_READY,
   input wire logic       CMD_REJECT,
   input wire logic       MAKER_A_EN,
   // link side
   input wire logic       TX_VALID,
   input wire logic [7:0] TX_BYTE,
   input wire logic       TX_LAST,
   input wire logic       TX_READY,
   input wire logic       RX_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic       RX_LAST,
   // answers
   input wire logic       REPLY_VALID,
   input wire logic [7:0] REPLY_CODE,
   input wire logic       ALERT_ACTIVE,
   input wire logic       FAULT_SEEN
);
   logic       tx_first_reg;
   logic       rx_first_reg;
   logic [7:0] rx_code_reg;
   // only the opening octet of a frame is a command code
   wire logic  tx_head = TX_VALID && tx_first_reg;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   always_ff @(posedge MCLK)
   begin
      if (RST) tx_first_reg <= 1'b1;
      else if (TX_VALID && TX_READY) tx_first_reg <= TX_LAST;
   end
   always_ff @(posedge MCLK)
   begin
      if (RST) rx_first_reg <= 1'b1;
      else if (RX_VALID) rx_first_reg <= RX_LAST;
   end
   always_ff @(posedge MCLK)
   begin
      if (RX_VALID && rx_first_reg) rx_code_reg <= RX_BYTE;
   end
   link_char_a: assert property (
      tx_head |-> !(TX_BYTE inside {`LINK_ACK, `LINK_NAK, `LINK_XON, `LINK_XOFF})) else $error("link char sent");
   maker_b_a: assert property (
      tx_head |-> !(TX_BYTE inside {[`CC_MAKER_B_LO:`CC_MAKER_B_HI]})) else $error("maker code sent");
   maker_gate_a: assert property (
      tx_head && TX_BYTE inside {[`CC_MAKER_A_LO:`CC_MAKER_A_HI]} |-> MAKER_A_EN) else $error("maker code ungated");
   station_code_a: assert property (
      tx_head |-> !(TX_BYTE inside {`CC_ALERT_ON, `CC_ALERT_OFF, [`CC_STATUS_REPLY:`CC_POWER_REPLY],
      `CC_SHORT_TEXT, `CC_NO_SHORT_TEXT, `CC_INTERNAL_FAULT, `CC_UNPERFORMABLE})) else $error("station code sent");
   tx_hold_a: assert property (
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE) && $stable(TX_LAST)) else $error("tx octet dropped");
   answer_time_a: assert property (
      CMD_VALID && CMD_READY && CMD_LAST |-> ##[1:3] (TX_VALID || CMD_REJECT)) else $error("no send or refusal");
   reject_quiet_a: assert property (
      CMD_REJECT |-> !TX_VALID [*4]) else $error("refused message sent");
   reply_time_a: assert property (
      RX_VALID && RX_LAST |=> REPLY_VALID && REPLY_CODE == rx_code_reg) else $error("reply late or wrong");
   alert_level_a: assert property (
      REPLY_VALID && REPLY_CODE == `CC_ALERT_ON |-> ##[0:1] ALERT_ACTIVE) else $error("alert level wrong");
   fault_stick_a: assert property (
      FAULT_SEEN |=> FAULT_SEEN) else $error("fault flag lost");
endmodule : host_checker

/* tb/station_model.sv */
`timescale 1ns/1ps
`include "test_port_consts.svh"
module station_model (
   // link from the host
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic       tx_last,
   output logic           tx_ready,
   // answer toward the host
   output logic           rx_valid,
   output logic [7:0]     rx_byte,
   output logic           rx_last,
   // scenario knobs
   input wire logic [3:0] slow,
   input wire logic       alert,
   input wire logic       fault,
   input wire logic       wrong
);
   logic [7:0] code;
   logic [7:0] ans[$];
   logic       first = 1'b1;
   int         n_oct = 0;
   logic [7:0] last_oct = 8'h00;
   initial
   begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_last  = 1'b0;
      rx_byte  = 8'h5A;
      forever
      begin
         @(posedge clk);
         if (rst || tx_valid !== 1'b1) continue;
         repeat (slow) @(posedge clk);
         #1 tx_ready = 1'b1;
         @(posedge clk);
         if (first) code = tx_byte;
         n_oct    = first ? 1 : n_oct + 1;
         last_oct = tx_byte;
         first = tx_last;
         #1 tx_ready = 1'b0;
         if (!first) continue;
         case (code)
            `CC_STATUS_REQ:     ans = {`CC_STATUS_REPLY, 8'h11};
            `CC_INDIC_REQ:      ans = {`CC_INDIC_REPLY, 8'h01};
            `CC_POWER_REQ:      ans = {`CC_POWER_REPLY, 8'h05};
            `CC_ALERT_REQ:      ans = {alert ? `CC_ALERT_ON : `CC_ALERT_OFF};
            `CC_SHORT_TEXT_REQ: ans = {`CC_NO_SHORT_TEXT};
            `CC_FULL_RESET:     ans = {};
            default:            ans = {`CC_UNRECOGNISED};
         endcase
         // a fault report replaces the whole answer, and is sent even after full reset
         if (fault) ans = {`CC_INTERNAL_FAULT, 8'h7E};
         if (wrong) ans[0] = ans[0] ^ 8'h01;
         repeat (slow + 1) @(posedge clk);
         #1;
         foreach (ans[i])
         begin
            rx_valid = 1'b1;
            rx_byte  = ans[i];
            rx_last  = (i == ans.size() - 1);
            @(posedge clk);
            #1;
         end
         // released line shows no stale octet
         rx_valid = 1'b0;
         rx_last  = 1'b0;
         rx_byte  = ~rx_byte;
      end
   end
endmodule : station_model

/* tb/tb_test_port_host.sv */
`timescale 1ns/1ps
`include "test_port_consts.svh"
module tb_test_port_host;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        cmd_valid = 1'b0;
   logic [7:0]  cmd_byte = 8'h00;
   logic        cmd_last = 1'b0;
   logic        maker_a_en = 1'b0;
   logic        cmd_ready, cmd_reject, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
   logic [7:0]  tx_byte, rx_byte, reply_code, reply_arg;
   logic        reply_valid, alert_active, fault_seen, proto_error;
   logic [3:0]  slow = 4'h1;
   logic        alert = 1'b0;
   logic        fault = 1'b0;
   logic        wrong = 1'b0;
   logic [16:0] exp_q[$];
   logic [16:0] got;
   logic [7:0]  bad[10] = '{8'h06, 8'h15, 8'h11, 8'h13, 8'hD2, 8'hEF, 8'hF0, 8'hF2, 8'hF3, 8'h3C};
   logic [15:0] rq_ans[3] = '{{`CC_STATUS_REPLY, 8'h11}, {`CC_INDIC_REPLY, 8'h01}, {`CC_POWER_REPLY, 8'h05}};
   int          n_errors = 0;
   int          samples_checked = 0;
   int          n_proto = 0;
   int          seed = 23223;
   always #2 mclk = ~mclk;
   test_port_host uut (.MCLK(mclk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte), .CMD_LAST(cmd_last),
      .MAKER_A_EN(maker_a_en), .CMD_READY(cmd_ready), .CMD_REJECT(cmd_reject), .TX_VALID(tx_valid),
      .TX_BYTE(tx_byte), .TX_LAST(tx_last), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
      .RX_LAST(rx_last), .REPLY_VALID(reply_valid), .REPLY_CODE(reply_code), .REPLY_ARG(reply_arg),
      .ALERT_ACTIVE(alert_active), .FAULT_SEEN(fault_seen), .PROTO_ERROR(proto_error));
   station_model peer (.clk(mclk), .rst(rst), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .slow(slow),
      .alert(alert), .fault(fault), .wrong(wrong));
   task automatic check(input logic [16:0] exp, input logic [16:0] act);
      samples_checked++;
      if (exp !== act)
      begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, act, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   // exp zero means no answer is due; bit 16 marks a refusal
   task automatic msg(input logic [7:0] b0, input logic [7:0] b1, input int n, input logic [16:0] exp);
      int k;
      if (exp !== 17'h0) exp_q.push_back(exp);
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk);
         cmd_valid = 1'b1;
         cmd_byte  = (i == 0) ? b0 : b1;
         cmd_last  = (i == n - 1);
         // ready moves only on a rising edge, so its level here is what the next edge sees
         k = 0;
         while (cmd_ready !== 1'b1 && k++ < 50) @(negedge mclk);
         @(posedge mclk);
      end
      @(negedge mclk);
      cmd_valid = 1'b0;
      repeat (4) @(negedge mclk);
      k = 0;
      while (cmd_ready !== 1'b1 && k++ < 200) @(negedge mclk);
      if (cmd_ready !== 1'b1)
      begin
         n_errors++;
         $display("ERROR %0t: command port stuck", $time);
      end
   endtask : msg
   always @(negedge mclk)
   begin
      if (!rst && (reply_valid === 1'b1 || cmd_reject === 1'b1))
      begin
         got = (cmd_reject === 1'b1) ? 17'h10000 : {1'b0, reply_code, reply_arg};
         if (exp_q.size() == 0) check(17'h1FFFF, got);
         else check(exp_q.pop_front(), got);
      end
      if (proto_error === 1'b1) n_proto++;
   end
   initial
   begin
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      foreach (bad[i]) msg(bad[i], 8'h00, 1, 17'h10000);
      for (int i = 0; i < 4; i++) msg(8'h67 + 8'($unsigned($random(seed)) % 77), 8'h00, 1, 17'h10000);
      msg(`CC_KEYS, 8'h41, 2, 17'h10000);
      $display("test refusals done");
      msg(8'hB4, 8'h00, 1, 17'h10000);
      maker_a_en = 1'b1;
      msg(8'hB4, 8'h00, 1, {1'b0, `CC_UNRECOGNISED, 8'h00});
      maker_a_en = 1'b0;
      $display("test maker codes done");
      for (int i = 0; i < 6; i++)
      begin
         slow = 4'($unsigned($random(seed)) % 6);
         msg(`CC_STATUS_REQ + 8'(i % 3), 8'h00, 1, {1'b0, rq_ans[i % 3]});
      end
      for (int i = 0; i < 2; i++)
      begin
         alert = (i == 1);
         msg(`CC_ALERT_REQ, 8'h00, 1, {1'b0, (i == 1) ? `CC_ALERT_ON : `CC_ALERT_OFF, 8'h00});
         check({16'h0, alert}, {16'h0, alert_active});
      end
      msg(`CC_SHORT_TEXT_REQ, 8'h00, 1, {1'b0, `CC_NO_SHORT_TEXT, 8'h00});
      msg(`CC_KEYS, `KEY_HASH, 3, {1'b0, `CC_UNRECOGNISED, 8'h00});
      check({1'b0, 8'h03, `KEY_HASH}, {1'b0, 8'(peer.n_oct), peer.last_oct});
      msg(`CC_TX_POWER_SET, 8'h05, 2, {1'b0, `CC_UNRECOGNISED, 8'h00});
      check({1'b0, 8'h02, 8'h05}, {1'b0, 8'(peer.n_oct), peer.last_oct});
      $display("test requests done");
      fault = 1'b1;
      msg(`CC_INDIC_REQ, 8'h00, 1, {1'b0, `CC_INTERNAL_FAULT, 8'h7E});
      fault = 1'b0;
      check(17'h1, {16'h0, fault_seen});
      wrong = 1'b1;
      msg(`CC_STATUS_REQ, 8'h00, 1, {1'b0, 8'h5A, 8'h11});
      wrong = 1'b0;
      check(17'h1, 17'(n_proto));
      $display("test faults done");
      msg(`CC_FULL_RESET, 8'h00, 1, 17'h0);
      check({9'h0, `CC_FULL_RESET}, {9'h0, peer.code});
      msg(`CC_INDIC_REQ, 8'h00, 1, {1'b0, `CC_INDIC_REPLY, 8'h01});
      repeat (5) @(negedge mclk);
      check(17'h0, 17'(exp_q.size()));
      $display("test reset done");
      give_verdict();
   end
   initial
   begin
      #200000;
      n_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule : tb_test_port_host
bind test_port_host host_checker chk (.MCLK(MCLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_LAST(CMD_LAST),
   .CMD_READY(CMD_READY), .CMD_REJECT(CMD_REJECT), .MAKER_A_EN(MAKER_A_EN), .TX_VALID(TX_VALID),
   .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
   .RX_LAST(RX_LAST), .REPLY_VALID(REPLY_VALID), .REPLY_CODE(REPLY_CODE), .ALERT_ACTIVE(ALERT_ACTIVE),
   .FAULT_SEEN(FAULT_SEEN));
